// ---- common/host_pci_window_cfg.svh ----
/*
 holds: configuration offsets, write masks, field positions and reset values
 of the bridge window registers.
 assumes: included by bare name wherever the values are needed.
*/
`ifndef HOST_PCI_WINDOW_CFG_SVH
`define HOST_PCI_WINDOW_CFG_SVH

// register window
`define CFG_FIRST          8'h44
`define CFG_LAST           8'h56
`define CFG_COUNT          19

// register offsets
`define CFG_PF0_BASE_LO    8'h44
`define CFG_PF0_BASE_HI    8'h45
`define CFG_PF1_BASE_LO    8'h46
`define CFG_PF1_BASE_HI    8'h47
`define CFG_PF0_SEL        8'h48
`define CFG_PF1_SEL        8'h49
`define CFG_PW0_BASE_LO    8'h4c
`define CFG_PW0_BASE_HI    8'h4d
`define CFG_PW1_BASE_LO    8'h4e
`define CFG_PW1_BASE_HI    8'h4f
`define CFG_PW0_SEL        8'h50
`define CFG_PW1_SEL        8'h51
`define CFG_IDE1_LO        8'h52
`define CFG_IDE1_HI        8'h53
`define CFG_IDE2_LO        8'h54
`define CFG_IDE2_HI        8'h55
`define CFG_CLK_SEL        8'h56

// writable bits per register kind
`define MASK_FULL          8'hff
`define MASK_SEL_LEGACY    8'h9f
`define MASK_SEL_PLAIN     8'h1f
`define MASK_IDE_LO        8'hf9
`define MASK_CLK           8'h03
`define MASK_NONE          8'h00

// fields
`define LEGACY_BIT         7
`define SIZE_MSB           4
`define IDE_EN_BIT         0
`define IDE_BASE_LSB       3
`define CLK_MSB            1

// size codes
`define SIZE_OFF           5'h00
`define SIZE_MAX_CMP       5'h10
`define SIZE_ALL           5'h11

// address layout
`define CMP_LSB            16
`define LEGACY_LSB         17
`define LEGACY_SEG         15'h0005

`define CFG_RESET_VAL      8'h00

`endif

// ---- common/host_pci_window_pkg.sv ----
/*
 holds: types shared by the bridge window logic.
 assumes: nothing beyond a SystemVerilog compiler.
*/
package host_pci_window_pkg;

    typedef logic [7:0]  cfg_byte_t;
    typedef logic [4:0]  size_code_t;
    typedef logic [15:0] mem_base_t;
    typedef logic [12:0] io_base_t;

    typedef enum logic [1:0] {
        CLK_ASYNC   = 2'b00,
        CLK_SYNC    = 2'b10,
        CLK_SYNC_2X = 2'b11
    } clk_mode_e;

endpackage : host_pci_window_pkg

// ---- src/range_match.sv ----
/*
 holds: one memory range comparator with base and power-of-two size code.
 assumes: inputs are stable on the core clock; output is combinational.
*/
`timescale 1ns/10ps
`default_nettype none
`include "host_pci_window_cfg.svh"

module range_match (
    input  wire logic                            addr_valid,
    input  wire logic [31:0]                     addr,
    input  wire host_pci_window_pkg::mem_base_t  base,
    input  wire host_pci_window_pkg::size_code_t size,
    output logic                                 hit
);

    logic [15:0] bit_ok;
    logic        sized;
    logic        all_range;
    logic [4:0]  low_step;

    assign sized     = (size != `SIZE_OFF) && (size <= `SIZE_MAX_CMP);
    assign all_range = (size == `SIZE_ALL);
    assign low_step  = size - 5'd1;

    // bit i stands for address bit 16+i; code s compares from bit 15+s upward
    for (genvar i = 0; i < 16; i++) begin : g_bit
        assign bit_ok[i] = (5'(i) < low_step) ||
                           (addr[`CMP_LSB + i] == base[i]);
    end

    assign hit = addr_valid && ((sized && (&bit_ok)) || all_range);

endmodule : range_match

`default_nettype wire

// ---- src/ide_io_match.sv ----
/*
 holds: one IDE burstable I/O address comparator.
 assumes: inputs are stable on the core clock; output is combinational.
*/
`timescale 1ns/10ps
`default_nettype none

module ide_io_match (
    input  wire logic                          io_valid,
    input  wire logic [15:0]                   io_addr,
    input  wire host_pci_window_pkg::io_base_t base,
    input  wire logic                          enable,
    output logic                               hit
);

    assign hit = io_valid && enable && (io_addr[15:3] == base);

endmodule : ide_io_match

`default_nettype wire

// ---- src/host_pci_window_range_decode.sv ----
/*
 holds: configuration registers and address-match logic for the bridge's
 prefetch, post-write and IDE burst windows, plus the PCI clock mode select.
 assumes: byte configuration accesses on the core clock from the host's
 configuration mechanism; cycle qualifiers arrive from same-clock logic.
*/
//
// Contract
// - segment bit makes A0000-BFFFF prefetchable
// - prefetch range 0 size zero disables it
// - code 10001 matches all; higher codes undefined
// - prefetch range 1 same size field, no segment
// - reserved bits read zero, ignore writes
// - post-write range 0 base A16-A31, reset zero
// - post-write range 1 base A16-A31, reset zero
// - segment bit makes A/B segments post-writable
// - post-write range 1 same encoding, reset disabled
// - IDE address 1 holds A3-A15 and enable
// - IDE address 2 independent, enable reset clear
// - clock mode 00 async, 10 sync
// - clock mode 11 sync, CPU twice PCI
// - prefetch range 0 base A16-A31, reset zero
`timescale 1ns/10ps
`default_nettype none
`include "host_pci_window_cfg.svh"

module host_pci_window_range_decode (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    input  wire logic [7:0]  cfg_wdata,
    output logic      [7:0]  cfg_rdata_q,
    input  wire logic        mem_cycle,
    input  wire logic        mem_write,
    input  wire logic [31:0] mem_addr,
    input  wire logic        io_cycle,
    input  wire logic [15:0] io_addr,
    output logic             prefetch_hit_q,
    output logic             post_write_hit_q,
    output logic      [1:0]  ide_burst_hit_q,
    output logic             pci_sync_mode_q,
    output logic             cpu_clk_2x_q
);

    localparam int N_REG = `CFG_COUNT;

    // writable bits for each byte in the window; unmapped bytes hold none
    localparam logic [7:0] WMASK [N_REG] = '{
        `MASK_FULL,       // prefetch 0 base low
        `MASK_FULL,       // prefetch 0 base high
        `MASK_FULL,       // prefetch 1 base low
        `MASK_FULL,       // prefetch 1 base high
        `MASK_SEL_LEGACY, // prefetch 0 select
        `MASK_SEL_PLAIN,  // prefetch 1 select
        `MASK_NONE,       // unmapped
        `MASK_NONE,       // unmapped
        `MASK_FULL,       // post-write 0 base low
        `MASK_FULL,       // post-write 0 base high
        `MASK_FULL,       // post-write 1 base low
        `MASK_FULL,       // post-write 1 base high
        `MASK_SEL_LEGACY, // post-write 0 select
        `MASK_SEL_PLAIN,  // post-write 1 select
        `MASK_IDE_LO,     // ide 1 low
        `MASK_FULL,       // ide 1 high
        `MASK_IDE_LO,     // ide 2 low
        `MASK_FULL,       // ide 2 high
        `MASK_CLK         // clock mode
    };

    if (N_REG != int'(`CFG_LAST) - int'(`CFG_FIRST) + 1) begin : g_check
        $error("register window size does not match its offsets");
    end

    host_pci_window_pkg::cfg_byte_t regs_q [N_REG];

    logic [7:0] rd_offset;
    logic [4:0] rd_idx;
    logic       rd_in_window;
    logic [7:0] rd_byte;

    // register file: each byte takes only its writable bits
    for (genvar i = 0; i < N_REG; i++) begin : g_reg
        logic wr_hit;
        assign wr_hit = cfg_wr && (cfg_addr == 8'(int'(`CFG_FIRST) + i));
        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                regs_q[i] <= `CFG_RESET_VAL;
            end else if (wr_hit) begin
                regs_q[i] <= cfg_wdata & WMASK[i];
            end
        end
    end

    // read path: registered, zero outside the window
    assign rd_offset    = cfg_addr - `CFG_FIRST;
    assign rd_idx       = rd_offset[4:0];
    assign rd_in_window = (cfg_addr >= `CFG_FIRST) && (cfg_addr <= `CFG_LAST);
    assign rd_byte      = rd_in_window ? regs_q[rd_idx] : 8'h00;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cfg_rdata_q <= 8'h00;
        end else begin
            cfg_rdata_q <= cfg_rd ? rd_byte : 8'h00;
        end
    end

    // field views
    host_pci_window_pkg::mem_base_t  pf0_base;
    host_pci_window_pkg::mem_base_t  pf1_base;
    host_pci_window_pkg::mem_base_t  pw0_base;
    host_pci_window_pkg::mem_base_t  pw1_base;
    host_pci_window_pkg::size_code_t pf0_size;
    host_pci_window_pkg::size_code_t pf1_size;
    host_pci_window_pkg::size_code_t pw0_size;
    host_pci_window_pkg::size_code_t pw1_size;
    host_pci_window_pkg::io_base_t   ide1_base;
    host_pci_window_pkg::io_base_t   ide2_base;
    host_pci_window_pkg::clk_mode_e  clk_mode;
    logic                            pf_legacy;
    logic                            pw_legacy;
    logic                            ide1_en;
    logic                            ide2_en;

    localparam int I_PF0_LO  = int'(`CFG_PF0_BASE_LO - `CFG_FIRST);
    localparam int I_PF0_HI  = int'(`CFG_PF0_BASE_HI - `CFG_FIRST);
    localparam int I_PF1_LO  = int'(`CFG_PF1_BASE_LO - `CFG_FIRST);
    localparam int I_PF1_HI  = int'(`CFG_PF1_BASE_HI - `CFG_FIRST);
    localparam int I_PF0_SEL = int'(`CFG_PF0_SEL - `CFG_FIRST);
    localparam int I_PF1_SEL = int'(`CFG_PF1_SEL - `CFG_FIRST);
    localparam int I_PW0_LO  = int'(`CFG_PW0_BASE_LO - `CFG_FIRST);
    localparam int I_PW0_HI  = int'(`CFG_PW0_BASE_HI - `CFG_FIRST);
    localparam int I_PW1_LO  = int'(`CFG_PW1_BASE_LO - `CFG_FIRST);
    localparam int I_PW1_HI  = int'(`CFG_PW1_BASE_HI - `CFG_FIRST);
    localparam int I_PW0_SEL = int'(`CFG_PW0_SEL - `CFG_FIRST);
    localparam int I_PW1_SEL = int'(`CFG_PW1_SEL - `CFG_FIRST);
    localparam int I_IDE1_LO = int'(`CFG_IDE1_LO - `CFG_FIRST);
    localparam int I_IDE1_HI = int'(`CFG_IDE1_HI - `CFG_FIRST);
    localparam int I_IDE2_LO = int'(`CFG_IDE2_LO - `CFG_FIRST);
    localparam int I_IDE2_HI = int'(`CFG_IDE2_HI - `CFG_FIRST);
    localparam int I_CLK     = int'(`CFG_CLK_SEL - `CFG_FIRST);

    assign pf0_base  = {regs_q[I_PF0_HI], regs_q[I_PF0_LO]};
    assign pf1_base  = {regs_q[I_PF1_HI], regs_q[I_PF1_LO]};
    assign pw0_base  = {regs_q[I_PW0_HI], regs_q[I_PW0_LO]};
    assign pw1_base  = {regs_q[I_PW1_HI], regs_q[I_PW1_LO]};
    assign pf0_size  = regs_q[I_PF0_SEL][`SIZE_MSB:0];
    assign pf1_size  = regs_q[I_PF1_SEL][`SIZE_MSB:0];
    assign pw0_size  = regs_q[I_PW0_SEL][`SIZE_MSB:0];
    assign pw1_size  = regs_q[I_PW1_SEL][`SIZE_MSB:0];
    assign pf_legacy = regs_q[I_PF0_SEL][`LEGACY_BIT];
    assign pw_legacy = regs_q[I_PW0_SEL][`LEGACY_BIT];
    assign ide1_base = {regs_q[I_IDE1_HI], regs_q[I_IDE1_LO][7:`IDE_BASE_LSB]};
    assign ide2_base = {regs_q[I_IDE2_HI], regs_q[I_IDE2_LO][7:`IDE_BASE_LSB]};
    assign ide1_en   = regs_q[I_IDE1_LO][`IDE_EN_BIT];
    assign ide2_en   = regs_q[I_IDE2_LO][`IDE_EN_BIT];
    assign clk_mode  = host_pci_window_pkg::clk_mode_e'(regs_q[I_CLK][`CLK_MSB:0]);

    // cycle qualifiers
    logic mem_read_cyc;
    logic mem_write_cyc;
    logic in_legacy;

    assign mem_read_cyc  = mem_cycle && !mem_write;
    assign mem_write_cyc = mem_cycle && mem_write;
    assign in_legacy     = (mem_addr[31:`LEGACY_LSB] == `LEGACY_SEG);

    logic pf0_hit;
    logic pf1_hit;
    logic pw0_hit;
    logic pw1_hit;
    logic ide1_hit;
    logic ide2_hit;

    range_match u_pf0 (
        .addr_valid (mem_read_cyc),
        .addr       (mem_addr),
        .base       (pf0_base),
        .size       (pf0_size),
        .hit        (pf0_hit)
    );

    range_match u_pf1 (
        .addr_valid (mem_read_cyc),
        .addr       (mem_addr),
        .base       (pf1_base),
        .size       (pf1_size),
        .hit        (pf1_hit)
    );

    range_match u_pw0 (
        .addr_valid (mem_write_cyc),
        .addr       (mem_addr),
        .base       (pw0_base),
        .size       (pw0_size),
        .hit        (pw0_hit)
    );

    range_match u_pw1 (
        .addr_valid (mem_write_cyc),
        .addr       (mem_addr),
        .base       (pw1_base),
        .size       (pw1_size),
        .hit        (pw1_hit)
    );

    ide_io_match u_ide1 (
        .io_valid (io_cycle),
        .io_addr  (io_addr),
        .base     (ide1_base),
        .enable   (ide1_en),
        .hit      (ide1_hit)
    );

    ide_io_match u_ide2 (
        .io_valid (io_cycle),
        .io_addr  (io_addr),
        .base     (ide2_base),
        .enable   (ide2_en),
        .hit      (ide2_hit)
    );

    logic pf_hit_d;
    logic pw_hit_d;
    logic sync_d;
    logic x2_d;

    assign pf_hit_d = pf0_hit || pf1_hit || (mem_read_cyc && pf_legacy && in_legacy);
    assign pw_hit_d = pw0_hit || pw1_hit || (mem_write_cyc && pw_legacy && in_legacy);
    assign sync_d   = (clk_mode == host_pci_window_pkg::CLK_SYNC) ||
                      (clk_mode == host_pci_window_pkg::CLK_SYNC_2X);
    assign x2_d     = (clk_mode == host_pci_window_pkg::CLK_SYNC_2X);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            prefetch_hit_q   <= 1'b0;
            post_write_hit_q <= 1'b0;
            ide_burst_hit_q  <= 2'b00;
            pci_sync_mode_q  <= 1'b0;
            cpu_clk_2x_q     <= 1'b0;
        end else begin
            prefetch_hit_q   <= pf_hit_d;
            post_write_hit_q <= pw_hit_d;
            ide_burst_hit_q  <= {ide2_hit, ide1_hit};
            pci_sync_mode_q  <= sync_d;
            cpu_clk_2x_q     <= x2_d;
        end
    end

    // checks
    sequence s_pw0_lo_write;
        cfg_wr && (cfg_addr == `CFG_PW0_BASE_LO);
    endsequence

    sequence s_pw0_lo_read;
        cfg_rd && !cfg_wr && (cfg_addr == `CFG_PW0_BASE_LO);
    endsequence

    sequence s_clk_write;
        cfg_wr && (cfg_addr == `CFG_CLK_SEL);
    endsequence

    property p_legacy_prefetch;
        @(posedge core_clk) disable iff (reset)
        (mem_read_cyc && pf_legacy && in_legacy) |=> prefetch_hit_q;
    endproperty
    a_legacy_prefetch: assert property (p_legacy_prefetch)
        else $error("legacy segment read not prefetchable");

    property p_size_off;
        @(posedge core_clk) disable iff (reset)
        (pf0_size == 5'h00 && pf1_size == 5'h00 && !pf_legacy) |=> !prefetch_hit_q;
    endproperty
    a_size_off: assert property (p_size_off)
        else $error("prefetch hit with all ranges disabled");

    property p_size_one;
        @(posedge core_clk) disable iff (reset)
        (mem_read_cyc && pf0_size == 5'h01 && mem_addr[31:16] == pf0_base) |=> prefetch_hit_q;
    endproperty
    a_size_one: assert property (p_size_one)
        else $error("64K range did not hit on matching address");

    property p_size_mismatch;
        @(posedge core_clk) disable iff (reset)
        (mem_write_cyc && pw0_size == 5'h10 && pw1_size == 5'h00 && !pw_legacy &&
         mem_addr[31] != pw0_base[15]) |=> !post_write_hit_q;
    endproperty
    a_size_mismatch: assert property (p_size_mismatch)
        else $error("2G post-write range hit with A31 differing");

    property p_all_range;
        @(posedge core_clk) disable iff (reset)
        (mem_read_cyc && pf1_size == 5'h11) |=> prefetch_hit_q;
    endproperty
    a_all_range: assert property (p_all_range)
        else $error("all-range code did not hit");

    property p_legacy_post;
        @(posedge core_clk) disable iff (reset)
        (mem_write_cyc && pw_legacy && in_legacy) |=> post_write_hit_q;
    endproperty
    a_legacy_post: assert property (p_legacy_post)
        else $error("legacy segment write not posted");

    property p_reserved_read;
        @(posedge core_clk) disable iff (reset)
        (cfg_rd && cfg_addr == `CFG_PF1_SEL) |=> (cfg_rdata_q[7:5] == 3'b000);
    endproperty
    a_reserved_read: assert property (p_reserved_read)
        else $error("reserved select bits read nonzero");

    property p_base_readback;
        @(posedge core_clk) disable iff (reset)
        (s_pw0_lo_write ##1 !cfg_wr ##1 s_pw0_lo_read) |=> (cfg_rdata_q == $past(cfg_wdata, 3));
    endproperty
    a_base_readback: assert property (p_base_readback)
        else $error("post-write base byte did not read back");

    property p_ide_hit;
        @(posedge core_clk) disable iff (reset)
        (io_cycle && ide2_en && io_addr[15:3] == ide2_base) |=> ide_burst_hit_q[1];
    endproperty
    a_ide_hit: assert property (p_ide_hit)
        else $error("enabled IDE address did not hit");

    property p_ide_off;
        @(posedge core_clk) disable iff (reset)
        !ide1_en |=> !ide_burst_hit_q[0];
    endproperty
    a_ide_off: assert property (p_ide_off)
        else $error("disabled IDE address hit");

    property p_clk_mode;
        @(posedge core_clk) disable iff (reset)
        s_clk_write |=> ##1 (pci_sync_mode_q == $past(cfg_wdata[1], 2) &&
                            cpu_clk_2x_q == (&$past(cfg_wdata[1:0], 2)));
    endproperty
    a_clk_mode: assert property (p_clk_mode)
        else $error("clock mode outputs do not follow the written code");

endmodule : host_pci_window_range_decode

`default_nettype wire

// ---- dv/host_bus_model.sv ----
/*
 holds: host side driver of the config byte port and the cpu cycle qualifiers.
 assumes: one core clock; a request is taken at the rising edge after it is set.
*/
`timescale 1ns/10ps
`default_nettype none

module host_bus_model (
    input  wire logic        core_clk,
    output logic      [7:0]  cfg_addr,
    output logic             cfg_wr,
    output logic             cfg_rd,
    output logic      [7:0]  cfg_wdata,
    output logic             mem_cycle,
    output logic             mem_write,
    output logic      [31:0] mem_addr,
    output logic             io_cycle,
    output logic      [15:0] io_addr
);
    initial begin
        {cfg_addr, cfg_wr, cfg_rd, cfg_wdata} = '0;
        {mem_cycle, mem_write, mem_addr, io_cycle, io_addr} = '0;
    end

    // one byte access; on release both strobes drop, address and data show the inverse of the last value
    task automatic cfg_op(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        cfg_wr <= wr;
        cfg_rd <= ~wr;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge core_clk);
        cfg_wr <= 1'b0;
        cfg_rd <= 1'b0;
        cfg_addr <= ~a;
        cfg_wdata <= ~d;
    endtask : cfg_op

    // one sampled cpu cycle
    task automatic cycle(input logic mc, input logic w, input logic [31:0] ma,
                         input logic ic, input logic [15:0] ia);
        @(posedge core_clk);
        mem_cycle <= mc;
        mem_write <= w;
        mem_addr <= ma;
        io_cycle <= ic;
        io_addr <= ia;
        @(posedge core_clk);
        mem_cycle <= 1'b0;
        io_cycle <= 1'b0;
        mem_addr <= ~ma;
        io_addr <= ~ia;
    endtask : cycle
endmodule : host_bus_model
`default_nettype wire

// ---- dv/tb.sv ----
/*
 holds: self-checking bench with a register and match model of the windows.
 assumes: host_bus_model drives every design input except clock and reset.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
    logic        core_clk;
    logic        reset = 1'b1;
    logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata_q;
    logic        cfg_wr, cfg_rd, mem_cycle, mem_write, io_cycle;
    logic [31:0] mem_addr;
    logic [15:0] io_addr;
    logic        prefetch_hit_q, post_write_hit_q, pci_sync_mode_q, cpu_clk_2x_q;
    logic [1:0]  ide_burst_hit_q;
    logic [7:0]  regs [0:255];
    int          num_errors = 0;
    int          check_count = 0;
    integer      seed = 32'h1e3f;
    int          bases [4] = '{'h44, 'h46, 'h4c, 'h4e};
    int          sels [4] = '{'h48, 'h49, 'h50, 'h51};
    logic [31:0] legacy_addrs [4] = '{32'h000a_0000, 32'h000b_ffff, 32'h0009_ffff, 32'h000c_0000};

    host_bus_model host (.core_clk(core_clk), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .mem_cycle(mem_cycle),
        .mem_write(mem_write), .mem_addr(mem_addr), .io_cycle(io_cycle), .io_addr(io_addr));

    host_pci_window_range_decode DUT (.core_clk(core_clk), .reset(reset),
        .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata),
        .cfg_rdata_q(cfg_rdata_q), .mem_cycle(mem_cycle), .mem_write(mem_write),
        .mem_addr(mem_addr), .io_cycle(io_cycle), .io_addr(io_addr),
        .prefetch_hit_q(prefetch_hit_q), .post_write_hit_q(post_write_hit_q),
        .ide_burst_hit_q(ide_burst_hit_q), .pci_sync_mode_q(pci_sync_mode_q),
        .cpu_clk_2x_q(cpu_clk_2x_q));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_of_test();
        if (num_errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    function automatic logic [7:0] wmask(input int a);
        case (a)
            'h44, 'h45, 'h46, 'h47, 'h4c, 'h4d, 'h4e, 'h4f, 'h53, 'h55: return 8'hff;
            'h48, 'h50: return 8'h9f;
            'h49, 'h51: return 8'h1f;
            'h52, 'h54: return 8'hf9;
            'h56: return 8'h03;
            default: return 8'h00;
        endcase
    endfunction : wmask

    function automatic logic rhit(input int b, input int sl, input logic [31:0] a);
        int s;
        s = regs[sl] & 31;
        if (s == 0 || s > 17)
            return 1'b0;
        if (s == 17)
            return 1'b1;
        return ({regs[b+1], regs[b], 16'h0000} >> (15 + s)) == (a >> (15 + s));
    endfunction : rhit

    task automatic do_reset();
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        for (int i = 0; i < 256; i++)
            regs[i] = 8'h00;
    endtask : do_reset

    task automatic wr(input int a, input logic [7:0] d);
        host.cfg_op(1'b1, a[7:0], d);
        regs[a] = d & wmask(a);
    endtask : wr

    task automatic rd(input int a);
        host.cfg_op(1'b0, a[7:0], 8'h00);
        #1;
        check("cfg_rdata_q", regs[a], cfg_rdata_q);
    endtask : rd

    task automatic read_all();
        for (int a = 'h40; a < 'h60; a++)
            rd(a);
    endtask : read_all

    task automatic probe(input logic mc, input logic w, input logic [31:0] ma,
                         input logic ic, input logic [15:0] ia);
        logic       leg;
        logic [1:0] ide;
        leg = ma[31:17] == 15'h0005;
        ide[0] = ic && regs['h52][0] && ia[15:3] == {regs['h53], regs['h52][7:3]};
        ide[1] = ic && regs['h54][0] && ia[15:3] == {regs['h55], regs['h54][7:3]};
        host.cycle(mc, w, ma, ic, ia);
        #1;
        check("prefetch_hit_q", mc && !w && (rhit('h44, 'h48, ma) || rhit('h46, 'h49, ma)
            || regs['h48][7] && leg), prefetch_hit_q);
        check("post_write_hit_q", mc && w && (rhit('h4c, 'h50, ma) || rhit('h4e, 'h51, ma)
            || regs['h50][7] && leg), post_write_hit_q);
        check("ide_burst_hit_q", ide, ide_burst_hit_q);
        check("pci_sync_mode_q", regs['h56][1], pci_sync_mode_q);
        check("cpu_clk_2x_q", regs['h56][1:0] == 2'b11, cpu_clk_2x_q);
    endtask : probe

    initial begin
        repeat (50000) @(posedge core_clk);
        num_errors++;
        end_of_test();
    end

    initial begin
        logic [31:0] r, ma;
        do_reset();
        read_all();
        probe(1'b1, 1'b0, 32'h000a_0000, 1'b1, 16'h0000);
        for (int a = 'h40; a < 'h60; a++) begin
            wr(a, 8'hff);
            rd(a);
        end
        for (int m = 0; m < 4; m++) begin
            wr('h56, m[7:0]);
            probe(1'b0, 1'b0, 32'h0, 1'b0, 16'h0);
        end
        do_reset();
        for (int i = 0; i < 4; i++) begin
            wr(bases[i], 8'h34);
            wr(bases[i] + 1, 8'h92);
            for (int s = 0; s < 20; s++) begin
                wr(sels[i], s[7:0]);
                for (int j = 0; j < 64; j++)
                    probe(1'b1, j[5], 32'h9234_0000 ^ (32'h1 << j[4:0]), 1'b0, 16'h0);
            end
            wr(sels[i], 8'h00);
        end
        wr('h48, 8'h80);
        wr('h50, 8'h80);
        foreach (legacy_addrs[k])
            for (int t = 0; t < 2; t++)
                probe(1'b1, t[0], legacy_addrs[k], 1'b0, 16'h0);
        wr('h52, 8'ha9);
        wr('h53, 8'h1f);
        wr('h54, 8'ha8);
        wr('h55, 8'h1f);
        for (int j = 0; j < 17; j++)
            probe(1'b0, 1'b0, 32'h0, 1'b1, 16'h1fa8 ^ (16'h1 << j[3:0]));
        wr('h54, 8'ha9);
        probe(1'b0, 1'b0, 32'h0, 1'b1, 16'h1fa8);
        for (int n = 0; n < 3000; n++) begin
            r = $random(seed);
            ma = $random(seed);
            case (r[1:0])
                2'd0: wr({3'b010, r[6:2]}, r[15:8]);
                2'd1: rd({3'b010, r[6:2]});
                default: begin
                    if (r[2])
                        ma = {regs[bases[r[4:3]] + 1], regs[bases[r[4:3]]], 16'h0}
                            ^ (32'h1 << ma[4:0]);
                    probe(r[5], r[6], ma, r[7], r[8] ? r[31:16]
                        : {regs['h53], regs['h52][7:3], 3'b000} ^ (16'h1 << r[12:9]));
                end
            endcase
        end
        do_reset();
        read_all();
        end_of_test();
    end
endmodule : tb
`default_nettype wire
